// *** rtl/ltmp_host.sv ***
// ltmp_host: host-side controller that drives a LIN transceiver's mode-select
// and transmit pins and watches its receive pin
// assumes one 20 MHz clock, the transceiver's receive pin arriving asynchronously
`timescale 1ns/10ps
module ltmp_host #(
  parameter int MODE_CYC = ltmp_pkg::MODE_HOLD_CYC,
  parameter int TXREC_CYC = ltmp_pkg::TX_RECOVERY_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire ltmp_pkg::ltmp_cmd_t cmd,
  input wire logic txBit,
  input wire logic rxdPin,
  output logic enPin,
  output logic txdPin,
  output ltmp_pkg::ltmp_status_t status
);

  // ----------------------------------------------------------------
  // receive pin synchronisation
  // ----------------------------------------------------------------
  logic rxSync;

  ltmp_sync #(
    .RESET_VAL(ltmp_pkg::RXD_IDLE)
  ) u_rx_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinIn(rxdPin),
    .levelOut(rxSync)
  );

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  ltmp_pkg::ltmp_state_t state_reg, state_next;
  logic [ltmp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic en_reg, en_next;
  logic txd_reg, txd_next;
  logic ready_reg, ready_next;
  logic wake_reg, wake_next;
  logic wakeSeen_reg, wakeSeen_next;
  logic rx_reg;

  // terminal count test shared by both timed states and the sleep blanking count
  function automatic logic cnt_done(input logic [ltmp_pkg::CNT_W-1:0] c, input int lim);
    cnt_done = (c >= ltmp_pkg::CNT_W'(lim - 1));
  endfunction

  // next-state logic; after reset the device is taken to sit in standby
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    en_next = en_reg;
    txd_next = txd_reg;
    ready_next = ready_reg;
    wake_next = 1'b0;
    wakeSeen_next = wakeSeen_reg;
    case (state_reg)
      ltmp_pkg::LTMP_STANDBY, ltmp_pkg::LTMP_SLEEP: begin
        en_next = 1'b0;
        txd_next = 1'b1;
        ready_next = 1'b0;
        if (cmd.reqNormal) begin
          state_next = ltmp_pkg::LTMP_MODE_HOLD;
          cnt_next = '0;
          en_next = 1'b1;
        end else if (state_reg == ltmp_pkg::LTMP_SLEEP && !cnt_done(cnt_reg, MODE_CYC + 2)) begin
          // receive line still shows the bus until the device acts on mode-select and
          // the synchroniser catches up; a stuck-dominant bus would read as a wake
          cnt_next = cnt_reg + 1'b1;
        end else if (state_reg == ltmp_pkg::LTMP_SLEEP && !rxSync) begin
          // receive low out of sleep means the device woke on the bus
          state_next = ltmp_pkg::LTMP_STANDBY;
          wake_next = 1'b1;
          wakeSeen_next = 1'b1;
        end
      end
      ltmp_pkg::LTMP_MODE_HOLD: begin
        txd_next = 1'b1;
        if (cmd.reqSleep) begin
          // dropping the mode-select line is the only sleep command
          state_next = ltmp_pkg::LTMP_SLEEP;
          cnt_next = '0;
          en_next = 1'b0;
        end else if (cnt_done(cnt_reg, MODE_CYC)) begin
          state_next = ltmp_pkg::LTMP_TX_REC;
          cnt_next = '0;
          wakeSeen_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ltmp_pkg::LTMP_TX_REC: begin
        txd_next = 1'b1;
        ready_next = 1'b0;
        if (cmd.reqSleep) begin
          state_next = ltmp_pkg::LTMP_SLEEP;
          cnt_next = '0;
          en_next = 1'b0;
        end else if (cnt_done(cnt_reg, TXREC_CYC)) begin
          state_next = ltmp_pkg::LTMP_ACTIVE;
          ready_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ltmp_pkg::LTMP_ACTIVE: begin
        txd_next = txBit;
        if (cmd.reqSleep) begin
          // sleep is commanded whatever the bus shows, even stuck dominant
          state_next = ltmp_pkg::LTMP_SLEEP;
          cnt_next = '0;
          en_next = 1'b0;
          txd_next = 1'b1;
          ready_next = 1'b0;
        end else if (cmd.recover) begin
          // transmitter may have been blocked: re-release with a high period
          state_next = ltmp_pkg::LTMP_TX_REC;
          cnt_next = '0;
          txd_next = 1'b1;
          ready_next = 1'b0;
        end
      end
      default: begin
        state_next = ltmp_pkg::LTMP_STANDBY;
        en_next = 1'b0;
        txd_next = 1'b1;
        ready_next = 1'b0;
      end
    endcase
  end

  // state registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ltmp_pkg::LTMP_STANDBY;
      cnt_reg <= '0;
      en_reg <= ltmp_pkg::EN_RESET;
      txd_reg <= ltmp_pkg::TXD_RESET;
      ready_reg <= 1'b0;
      wake_reg <= 1'b0;
      wakeSeen_reg <= 1'b0;
      rx_reg <= ltmp_pkg::RXD_IDLE;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      en_reg <= en_next;
      txd_reg <= txd_next;
      ready_reg <= ready_next;
      wake_reg <= wake_next;
      wakeSeen_reg <= wakeSeen_next;
      rx_reg <= rxSync;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign enPin = en_reg;
  assign txdPin = txd_reg;
  assign status.mode = state_reg;
  assign status.txReady = ready_reg;
  assign status.wakeEvent = wake_reg;
  assign status.wakeSeen = wakeSeen_reg;
  assign status.rxData = rx_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helper counters of consecutive high cycles on the driven pins
  logic [ltmp_pkg::CNT_W-1:0] enHi_reg, txHi_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enHi_reg <= '0;
      txHi_reg <= '0;
    end else begin
      enHi_reg <= enPin ? enHi_reg + 1'b1 : '0;
      txHi_reg <= txdPin ? txHi_reg + 1'b1 : '0;
    end
  end

  a_mode_hold_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($past(state_reg) == ltmp_pkg::LTMP_MODE_HOLD && state_reg == ltmp_pkg::LTMP_TX_REC)
    |-> (enHi_reg >= ltmp_pkg::CNT_W'(MODE_CYC)))
    else $error("normal mode reached before mode-select hold time");

  a_sleep_en_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd.reqSleep && state_reg == ltmp_pkg::LTMP_ACTIVE)
    |=> (!enPin && state_reg == ltmp_pkg::LTMP_SLEEP) ##1 !enPin)
    else $error("sleep request did not drop mode-select");

  a_sleep_bus_stuck: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd.reqSleep && !rxSync && state_reg != ltmp_pkg::LTMP_STANDBY
      && state_reg != ltmp_pkg::LTMP_SLEEP)
    |=> !enPin)
    else $error("sleep blocked by dominant bus");

  a_tx_release_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(ready_reg) |-> (txHi_reg >= ltmp_pkg::CNT_W'(TXREC_CYC)) && enPin)
    else $error("data released before transmit recovery time");

  a_recover_block: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd.recover && state_reg == ltmp_pkg::LTMP_ACTIVE && !cmd.reqSleep)
    |=> !ready_reg && state_reg == ltmp_pkg::LTMP_TX_REC)
    else $error("recovery did not block data");

  a_recover_txd_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd.recover && state_reg == ltmp_pkg::LTMP_ACTIVE && !cmd.reqSleep)
    |=> txdPin throughout (!ready_reg [*2]))
    else $error("transmit not held high after recovery");

endmodule

// *** rtl/ltmp_pkg.sv ***
// ltmp_pkg: shared constants and carriers for the LIN transceiver host controller
// assumes a single 20 MHz system clock; every timing count derives from it
package ltmp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50; // sys_clk at 20 MHz
  // mode change delay: the device needs mode-select high this long
  localparam int MODE_HOLD_NS = 20000;
  // transmit_recovery_time: transmit line high before data is released
  localparam int TX_RECOVERY_NS = 15000;
  // least times round up to whole cycles
  localparam int MODE_HOLD_CYC = (MODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_RECOVERY_CYC = (TX_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // reset values of the pins
  // ----------------------------------------------------------------
  localparam logic EN_RESET = 1'b0; // mode-select low: device stays in standby
  localparam logic TXD_RESET = 1'b1; // transmit line recessive
  localparam logic RXD_IDLE = 1'b1; // receive line idles high

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LTMP_STANDBY = 3'h0,
    LTMP_SLEEP = 3'h1,
    LTMP_MODE_HOLD = 3'h2,
    LTMP_TX_REC = 3'h3,
    LTMP_ACTIVE = 3'h4
  } ltmp_state_t;

  typedef struct packed {
    logic reqNormal; // pulse: bring the device to normal operation
    logic reqSleep; // pulse: send the device to sleep
    logic recover; // pulse: protection event suspected, resynchronise
  } ltmp_cmd_t;

  typedef struct packed {
    ltmp_state_t mode; // device mode as the host believes it
    logic txReady; // data on txBit reaches the bus
    logic wakeEvent; // one-cycle pulse: bus wake-up seen
    logic wakeSeen; // level: standby entered by bus wake-up
    logic rxData; // synchronised receive line
  } ltmp_status_t;

endpackage

// *** rtl/ltmp_sync.sv ***
// ltmp_sync: two flip-flop synchroniser for a pin level
// assumes the input is asynchronous to sys_clk; reset value is a parameter
`timescale 1ns/10ps
module ltmp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic levelOut
);

  logic meta_reg;
  logic level_reg;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  // first stage feeds only the second; nothing else may look at it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RESET_VAL;
      level_reg <= RESET_VAL;
    end else begin
      meta_reg <= pinIn;
      level_reg <= meta_reg;
    end
  end

  assign levelOut = level_reg;

endmodule

// *** tb/ltmp_dev_model.sv ***
// ltmp_dev_model: behavioural transceiver as the host controller sees it
// assumes pins sampled on sys_clk; protection levels come from the bench
`timescale 1ns/10ps
module ltmp_dev_model #(
  parameter int MODE_DLY = 4,
  parameter int REC_DLY = 3,
  parameter int WAKE_DLY = 3
) (
  input wire logic sys_clk,
  input wire logic enPin,
  input wire logic txdPin,
  input wire logic busShort,
  input wire logic overTemp,
  input wire logic underVolt,
  input wire logic porLow,
  output logic rxdPin,
  output logic busLevel
);
  logic [1:0] devMode; // 0 standby, 1 sleep, 2 normal
  logic txOn = 1'b0;
  logic wakeFlag = 1'b0;
  logic enPrev = 1'b0;
  int enCnt = 0;
  int recCnt = 0;
  int domCnt = 0;
  initial devMode = 2'h0;
  // ------------------------------------------------------------
  // mode and transmitter gating
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    enCnt <= (enPin === 1'b1) ? enCnt + 1 : 0;
    enPrev <= (enPin === 1'b1);
    domCnt <= busLevel ? 0 : domCnt + 1;
    if (porLow) begin
      devMode <= 2'h0;
      txOn <= 1'b0;
      wakeFlag <= 1'b0;
    end else if (devMode != 2'h2 && enPin === 1'b1 && enCnt >= MODE_DLY - 1) begin
      devMode <= 2'h2;
      txOn <= 1'b0;
      recCnt <= 0;
      wakeFlag <= 1'b0;
    end else if (devMode == 2'h2 && enPrev && enPin !== 1'b1) begin
      devMode <= 2'h1;
      txOn <= 1'b0;
    end else if (devMode == 2'h1 && busLevel && domCnt >= WAKE_DLY) begin
      devMode <= 2'h0;
      wakeFlag <= 1'b1;
    end else if (devMode == 2'h2) begin
      // over-temperature never touches the mode, only the driver
      recCnt <= (txdPin && !overTemp && !underVolt) ? recCnt + 1 : 0;
      if (overTemp || underVolt) txOn <= 1'b0;
      else if (recCnt >= REC_DLY - 1) txOn <= 1'b1;
    end
  end
  // bus recessive unless normal mode drives it or busShort holds it dominant; rxd is open drain, pulled high
  assign busLevel = !(busShort || (devMode == 2'h2 && txOn && !txdPin));
  assign rxdPin = (devMode == 2'h2) ? (underVolt | busLevel) :
                  (devMode == 2'h0) ? !wakeFlag : 1'b1;
endmodule

// *** tb/tb_top.sv ***
// tb_top: random and directed checks of the host controller against a device model
// assumes rtl/ltmp_pkg.sv and rtl/ltmp_host.sv are compiled first
`timescale 1ns/10ps
module tb_top;
  localparam int MC = 4;
  localparam int TC = 3;
  logic sys_clk, nrst, txBit, rxdPin, enPin, txdPin, busLevel, prevb, b;
  logic busShort, overTemp, underVolt, porLow;
  ltmp_pkg::ltmp_cmd_t cmd;
  ltmp_pkg::ltmp_status_t status;
  int err_count, n_checks, cyc, i;
  ltmp_host #(.MODE_CYC(MC), .TXREC_CYC(TC)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .cmd(cmd), .txBit(txBit), .rxdPin(rxdPin), .enPin(enPin), .txdPin(txdPin),
    .status(status));
  ltmp_dev_model #(.MODE_DLY(MC), .REC_DLY(TC), .WAKE_DLY(3)) dev (.sys_clk(sys_clk),
    .enPin(enPin), .txdPin(txdPin), .busShort(busShort), .overTemp(overTemp),
    .underVolt(underVolt), .porLow(porLow), .rxdPin(rxdPin), .busLevel(busLevel));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(logic [2:0] c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= 3'h0;
    @(negedge sys_clk);
  endtask
  task automatic wait_mode(int n, logic [3:0] m);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    check("mode", status.mode, m);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic go_normal();
    pulse(3'h4);
    check("enPin", enPin, 1);
    wait_mode(MC - 1, 2);
    check("txdPin", txdPin, 1);
    wait_mode(1, 3);
    wait_mode(TC - 1, 3);
    check("txReady", status.txReady, 0);
    wait_mode(1, 4);
    check("wakeSeen", status.wakeSeen, 0);
  endtask
  // a hang is cut short here
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {nrst, txBit, busShort, overTemp, underVolt, porLow, cmd} = 9'h080;
    {err_count, n_checks, cyc} = 0;
    b = 1'($urandom(32'h338299EE));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    pulse(3'h2); // sleep and recover are refused in standby
    pulse(3'h1);
    check("enPin", enPin, 0);
    check("mode", status.mode, 0);
    check("rxData", status.rxData, 1);
    go_normal();
    $display("test reset and normal entry done");
    for (i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      txBit <= b;
      @(negedge sys_clk);
      if (i > 0) check("txdPin", txdPin, prevb);
      if (i > 0) check("bus", busLevel, prevb);
      prevb = b;
      b = 1'($urandom);
    end
    $display("test random data done");
    // over-temperature then under-voltage in turn, each time the host resynchronises
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      txBit <= 1'b0;
      {overTemp, underVolt} <= i ? 2'h1 : 2'h2;
      repeat (3) @(posedge sys_clk);
      {overTemp, underVolt} <= 2'h0;
      pulse(3'h1);
      check("txdPin", txdPin, 1);
      check("txReady", status.txReady, 0);
      wait_mode(0, 3);
      wait_mode(TC - 2, 3);
      wait_mode(1, 4);
      wait_mode(1, 4);
      check("bus", busLevel, 0);
    end
    $display("test protection recovery done");
    @(posedge sys_clk);
    txBit <= 1'b1;
    pulse(3'h2);
    check("enPin", enPin, 0);
    check("txReady", status.txReady, 0);
    wait_mode(0, 1);
    @(posedge sys_clk);
    busShort <= 1'b1;
    repeat (5) @(posedge sys_clk);
    busShort <= 1'b0;
    for (i = 0; i < 10 && status.wakeEvent !== 1'b1; i++) @(negedge sys_clk);
    check("wakeEvent", status.wakeEvent, 1);
    check("wakeSeen", status.wakeSeen, 1);
    wait_mode(0, 0);
    go_normal();
    $display("test wake and re-entry done");
    @(posedge sys_clk);
    busShort <= 1'b1;
    // let the dominant level reach the synchronised receive line before the request
    repeat (2) @(posedge sys_clk);
    pulse(3'h2);
    check("enPin", enPin, 0);
    wait_mode(0, 1);
    wait_mode(2, 1);
    check("devMode", dev.devMode, 1);
    $display("test sleep on shorted bus done");
    // supply drops to the power-on level in normal mode, bus still shorted
    go_normal();
    check("rxData", status.rxData, 0);
    @(posedge sys_clk);
    porLow <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("devMode", dev.devMode, 0);
    check("rxData", status.rxData, 1);
    @(posedge sys_clk);
    porLow <= 1'b0;
    $display("test power-on reset done");
    conclude();
  end
endmodule
